// *** hw/cspc_pkg.sv ***
// cspc_pkg: register map, field positions, reset values and encodings for the
// clock source / pll configuration block.
// assumes an apb slave with 32-bit data; registers are 8 bits in the low lanes.
package cspc_pkg;
    localparam int          CSPC_AW            = 12;
    // printed offsets are not all multiples of four: kept as indices, byte address = 4 * index
    localparam logic [11:0] CSPC_IDX_PWR_POL   = 12'h010;
    localparam logic [11:0] CSPC_IDX_VCO_CAL   = 12'h018;
    localparam logic [11:0] CSPC_IDX_VDIV_SEL  = 12'h1e0;
    localparam logic [11:0] CSPC_IDX_DIST_SEL  = 12'h1e1;
    localparam logic [11:0] CSPC_IDX_UPDATE    = 12'h232;
    localparam logic [11:0] CSPC_IDX_STATUS    = 12'h233;
    // field positions
    localparam int          CSPC_PWR_LSB       = 0;
    localparam int          CSPC_POL_BIT       = 7;
    localparam int          CSPC_CAL_BIT       = 0;
    localparam int          CSPC_VDIV_LSB      = 0;
    localparam int          CSPC_BYP_BIT       = 0;
    localparam int          CSPC_SRC_BIT       = 1;
    localparam int          CSPC_UPD_BIT       = 0;
    // reset values and the update register write value
    localparam logic [7:0]  CSPC_RST_PWR_POL   = 8'h01;
    localparam logic [7:0]  CSPC_RST_VCO_CAL   = 8'h00;
    localparam logic [7:0]  CSPC_RST_VDIV_SEL  = 8'h02;
    localparam logic [7:0]  CSPC_RST_DIST_SEL  = 8'h00;
    localparam logic [7:0]  CSPC_UPD_VALUE     = 8'h01;
    // encodings
    localparam logic [1:0]  CSPC_PWR_RUN       = 2'h0;
    localparam logic [1:0]  CSPC_PWR_DOWN      = 2'h1;
    localparam logic [2:0]  CSPC_VDIV_MIN      = 3'h0;
    localparam logic [2:0]  CSPC_VDIV_MAX      = 3'h4;
    // timing: calibration busy window
    localparam int          CSPC_CAL_TIME_NS   = 1000;
    localparam int          CSPC_CLK_PERIOD_NS = 10;
    localparam int          CSPC_CAL_CYCLES    = (CSPC_CAL_TIME_NS + CSPC_CLK_PERIOD_NS - 1) / CSPC_CLK_PERIOD_NS;
endpackage : cspc_pkg

// *** hw/cspc_top.sv ***
// cspc_top: apb register file with staged/active copies, update strobe,
// pll power, polarity, vco divider, bypass, source select and calibration start.
// assumes one clock pclk (100 MHz) and an apb master with 32-bit data.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns

// Overview of operation
// RULE_01 - power field 01b powers pll down, 00b runs it
// RULE_02 - reset gives pll off, divide by four, divider in path, external clock
// RULE_03 - vco divider field selects divide two to six, 010b is four
// RULE_04 - bypass bit clear routes through divider, set feeds source directly
// RULE_05 - source bit clear picks external clock, set picks internal vco
// RULE_06 - polarity bit clear is positive, set is negative
// RULE_07 - staged values act only after host writes 0x01 to update register
// RULE_08 - calibration started by setting cal bit then update; clear before later runs
// RULE_09 - host powers pll, sets loop, divider, path, source, then calibrates
// RULE_10 - host keeps divider in path with internal vco, limit 1600 MHz
// RULE_11 - host bypasses divider only below 1600 MHz
// RULE_12 - with external vco host powers pll and sets loop registers
// RULE_13 - internal vco stays off when external clock is the source
// RULE_14 - external clock up to 2400 MHz through divider, minimum ratio two
// RULE_15 - eight-bit registers staged, moved to active copy on update write
// RULE_16 - calibration starts on active cal bit rising at an update only
module cspc_top
    import cspc_pkg::*;
#(
    parameter int CAL_CYCLES = cspc_pkg::CSPC_CAL_CYCLES  // calibration busy length
) (
    input  wire logic                         pclk,            // apb clock
    input  wire logic                         presetn,         // async reset, active low
    input  wire logic                         psel,            // apb select
    input  wire logic                         penable,         // apb enable
    input  wire logic                         pwrite,          // apb direction
    input  wire logic [cspc_pkg::CSPC_AW+1:0] paddr,           // apb byte address
    input  wire logic [31:0]                  pwdata,          // apb write data
    input  wire logic [3:0]                   pstrb,           // apb byte strobes
    output logic      [31:0]                  prdata,          // apb read data
    output logic                              pready,          // apb ready
    output logic                              pslverr,         // apb error
    output logic                              pll_powerdown,   // pll in async power-down
    output logic                              pfd_negative,    // phase detector polarity
    output logic      [2:0]                   vco_div_code,    // active divider code
    output logic                              vco_div_bypass,  // divider bypassed
    output logic                              src_internal_vco,// internal vco feeds distribution
    output logic                              int_vco_enable,  // internal vco powered
    output logic                              cal_start,       // one-cycle calibration start
    output logic                              cal_busy         // calibration in progress
);
    import cspc_pkg::*;

    // the busy counter is 16 bits; a zero length would pulse start with no busy window
    if (CAL_CYCLES < 1 || CAL_CYCLES > 65535) begin : g_bad_cal_cycles
        $error("cspc_top: CAL_CYCLES out of range");
    end

    typedef struct packed {
        logic [7:0]  stg_pwr;
        logic [7:0]  stg_cal;
        logic [7:0]  stg_vdiv;
        logic [7:0]  stg_dist;
        logic [7:0]  act_pwr;
        logic [7:0]  act_cal;
        logic [7:0]  act_vdiv;
        logic [7:0]  act_dist;
        logic [15:0] cal_cnt;
        logic        cal_start;
        logic        int_vco;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        pwr_down;
        logic        busy;
    } cspc_state_t;

    cspc_state_t st;
    cspc_state_t next_st;

    logic [CSPC_AW-1:0] idx;
    logic               word_ok;
    logic               setup;
    logic               wr_go;
    logic               hit;
    logic               upd;

    // register index from byte address; low two bits must be zero
    assign idx     = paddr[CSPC_AW+1:2];
    assign word_ok = (paddr[1:0] == 2'h0);
    assign setup   = psel && !penable;
    assign hit     = word_ok && (idx == CSPC_IDX_PWR_POL || idx == CSPC_IDX_VCO_CAL || idx == CSPC_IDX_VDIV_SEL
                     || idx == CSPC_IDX_DIST_SEL || idx == CSPC_IDX_UPDATE || idx == CSPC_IDX_STATUS);
    // access completes one cycle after setup: pready raised in access phase
    assign wr_go   = psel && penable && st.pready && pwrite && pstrb[0];
    assign upd     = wr_go && hit && idx == CSPC_IDX_UPDATE && pwdata[7:0] == CSPC_UPD_VALUE; // RULE_07

    always_comb begin
        next_st           = st;
        next_st.cal_start = 1'b0;
        next_st.pready    = setup;
        next_st.pslverr   = setup && !hit;
        next_st.prdata    = 32'h0;
        // read data captured at setup so it is steady through the access phase
        if (setup && !pwrite) begin
            case (idx)
                CSPC_IDX_PWR_POL:  next_st.prdata = {24'h0, st.stg_pwr};
                CSPC_IDX_VCO_CAL:  next_st.prdata = {24'h0, st.stg_cal};
                CSPC_IDX_VDIV_SEL: next_st.prdata = {24'h0, st.stg_vdiv};
                CSPC_IDX_DIST_SEL: next_st.prdata = {24'h0, st.stg_dist};
                CSPC_IDX_STATUS:   next_st.prdata = {29'h0, st.cal_cnt != 16'h0, st.int_vco, st.act_pwr[1:0] == CSPC_PWR_DOWN};
                default:           next_st.prdata = 32'h0; // update reads zero, unmapped errors
            endcase
            if (!word_ok) begin
                next_st.prdata = 32'h0;
            end
        end
        // staging writes; the active copy is untouched until an update
        if (wr_go && hit) begin // RULE_15
            case (idx)
                CSPC_IDX_PWR_POL:  next_st.stg_pwr  = pwdata[7:0];
                CSPC_IDX_VCO_CAL:  next_st.stg_cal  = pwdata[7:0];
                CSPC_IDX_VDIV_SEL: next_st.stg_vdiv = pwdata[7:0];
                CSPC_IDX_DIST_SEL: next_st.stg_dist = pwdata[7:0];
                default:           next_st.stg_pwr  = st.stg_pwr;
            endcase
        end
        // update: transfer staging to active, detect calibration bit rising
        if (upd) begin // RULE_07
            next_st.act_pwr  = st.stg_pwr;
            next_st.act_cal  = st.stg_cal;
            next_st.act_vdiv = st.stg_vdiv;
            next_st.act_dist = st.stg_dist;
            if (st.stg_cal[CSPC_CAL_BIT] && !st.act_cal[CSPC_CAL_BIT]) begin // RULE_16 RULE_08
                next_st.cal_start = 1'b1;
                next_st.cal_cnt   = 16'(CAL_CYCLES);
            end
        end
        if (st.cal_cnt != 16'h0 && !next_st.cal_start) begin
            next_st.cal_cnt = st.cal_cnt - 16'h1;
        end
        // internal vco runs only when the pll is on and the vco is the source
        next_st.int_vco = (next_st.act_pwr[1:0] == CSPC_PWR_RUN) && next_st.act_dist[CSPC_SRC_BIT]; // RULE_13
        // registered so the pins come straight from flip-flops, not from a compare
        next_st.pwr_down = (next_st.act_pwr[1:0] == CSPC_PWR_DOWN); // RULE_01
        next_st.busy     = (next_st.cal_cnt != 16'h0);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st          <= '0;
            st.stg_pwr  <= CSPC_RST_PWR_POL;  // RULE_02
            st.stg_cal  <= CSPC_RST_VCO_CAL;
            st.stg_vdiv <= CSPC_RST_VDIV_SEL;
            st.stg_dist <= CSPC_RST_DIST_SEL;
            st.act_pwr  <= CSPC_RST_PWR_POL;
            st.act_cal  <= CSPC_RST_VCO_CAL;
            st.act_vdiv <= CSPC_RST_VDIV_SEL;
            st.act_dist <= CSPC_RST_DIST_SEL;
            st.pwr_down <= 1'b1;  // pll off after reset
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state flip-flops: bus registers, active copy, vco enable, calibration start and busy
    assign prdata           = st.prdata;
    assign pready           = st.pready;
    assign pslverr          = st.pslverr;
    assign pll_powerdown    = st.pwr_down;                         // RULE_01
    assign pfd_negative     = st.act_pwr[CSPC_POL_BIT];            // RULE_06
    // out-of-range codes pass through; ratio = code + 2, so at least two
    assign vco_div_code     = st.act_vdiv[CSPC_VDIV_LSB+:3];       // RULE_03 RULE_14
    assign vco_div_bypass   = st.act_dist[CSPC_BYP_BIT];           // RULE_04
    assign src_internal_vco = st.act_dist[CSPC_SRC_BIT];           // RULE_05
    assign int_vco_enable   = st.int_vco;
    assign cal_start        = st.cal_start;
    assign cal_busy         = st.busy;

    // assertions
    property p_upd_transfer;
        @(posedge pclk) disable iff (!presetn)
        upd |=> (st.act_dist == $past(st.stg_dist) && st.act_pwr == $past(st.stg_pwr));
    endproperty
    a_upd_transfer: assert property (p_upd_transfer) else $error("active copy not loaded on update"); // RULE_07

    property p_no_upd_hold;
        @(posedge pclk) disable iff (!presetn)
        !upd |=> $stable(st.act_pwr) && $stable(st.act_vdiv) && $stable(st.act_dist);
    endproperty
    a_no_upd_hold: assert property (p_no_upd_hold) else $error("active copy changed without update"); // RULE_15

    property p_cal_rise;
        @(posedge pclk) disable iff (!presetn)
        cal_start |-> $past(upd) && !$past(st.act_cal[0]) && st.act_cal[0];
    endproperty
    a_cal_rise: assert property (p_cal_rise) else $error("calibration start without rising bit"); // RULE_16

    property p_cal_pulse;
        @(posedge pclk) disable iff (!presetn)
        cal_start |-> cal_busy ##1 !cal_start;
    endproperty
    a_cal_pulse: assert property (p_cal_pulse) else $error("calibration start not a single pulse"); // RULE_08

    property p_pwr_map;
        @(posedge pclk) disable iff (!presetn)
        pll_powerdown == (st.act_pwr[1:0] == 2'h1) && pfd_negative == st.act_pwr[7];
    endproperty
    a_pwr_map: assert property (p_pwr_map) else $error("power or polarity mismatch"); // RULE_01

    property p_vco_off;
        @(posedge pclk) disable iff (!presetn)
        !src_internal_vco |-> !int_vco_enable;
    endproperty
    a_vco_off: assert property (p_vco_off) else $error("internal vco on with external source"); // RULE_13

    property p_reset_vals;
        @(posedge pclk) $rose(presetn) |-> pll_powerdown && vco_div_code == 3'h2 && !vco_div_bypass && !src_internal_vco;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset defaults wrong"); // RULE_02

    property p_route;
        @(posedge pclk) disable iff (!presetn)
        upd |=> vco_div_bypass == $past(st.stg_dist[0]) && src_internal_vco == $past(st.stg_dist[1])
                && vco_div_code == $past(st.stg_vdiv[2:0]);
    endproperty
    a_route: assert property (p_route) else $error("routing not taken from update"); // RULE_04 RULE_05 RULE_03

    property p_apb_one_wait;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready;
    endproperty
    a_apb_one_wait: assert property (p_apb_one_wait) else $error("pready not one cycle after setup");

    property p_reset_out;
        @(posedge pclk)
        (!presetn ##1 !presetn) |-> pll_powerdown && !pready && !cal_start && !cal_busy && !int_vco_enable;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not at defaults during reset"); // RULE_02

    property p_pready_pulse;
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("pready stood longer than one cycle");

    property p_err_qual;
        @(posedge pclk) disable iff (!presetn)
        pslverr |-> pready;
    endproperty
    a_err_qual: assert property (p_err_qual) else $error("pslverr without pready");

    property p_rdata_idle;
        @(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside the access cycle");

    property p_rdata_width;
        @(posedge pclk) disable iff (!presetn)
        pready |-> prdata[31:8] == 24'h0;
    endproperty
    a_rdata_width: assert property (p_rdata_width) else $error("read data wider than eight bits"); // RULE_15

    property p_stage_pwr;
        @(posedge pclk) disable iff (!presetn)
        (wr_go && hit && idx == CSPC_IDX_PWR_POL) |=> st.stg_pwr == $past(pwdata[7:0]);
    endproperty
    a_stage_pwr: assert property (p_stage_pwr) else $error("staging copy not written"); // RULE_15

    property p_no_strobe;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && !pstrb[0])
            |=> $stable(st.stg_pwr) && $stable(st.stg_cal) && $stable(st.stg_vdiv) && $stable(st.stg_dist);
    endproperty
    a_no_strobe: assert property (p_no_strobe) else $error("write without byte strobe stored"); // RULE_15

    property p_upd_value;
        @(posedge pclk) disable iff (!presetn)
        (wr_go && hit && idx == CSPC_IDX_UPDATE && pwdata[7:0] != CSPC_UPD_VALUE) |=> $stable(st.act_pwr) && $stable(st.act_dist);
    endproperty
    a_upd_value: assert property (p_upd_value) else $error("update taken for a wrong value"); // RULE_07

    property p_busy_load;
        @(posedge pclk) disable iff (!presetn)
        cal_start |-> st.cal_cnt == 16'(CAL_CYCLES);
    endproperty
    a_busy_load: assert property (p_busy_load) else $error("busy window not loaded at start"); // RULE_08

    property p_busy_count;
        @(posedge pclk) disable iff (!presetn)
        cal_busy |=> cal_start || st.cal_cnt == $past(st.cal_cnt) - 16'h1;
    endproperty
    a_busy_count: assert property (p_busy_count) else $error("busy window not counting down"); // RULE_08

    property p_vco_needs_src;
        @(posedge pclk) disable iff (!presetn)
        int_vco_enable |-> src_internal_vco && !pll_powerdown;
    endproperty
    a_vco_needs_src: assert property (p_vco_needs_src) else $error("internal vco on without source or pll"); // RULE_13

    property p_cal_on_rise;
        @(posedge pclk) disable iff (!presetn)
        $rose(st.act_cal[CSPC_CAL_BIT]) |-> cal_start;
    endproperty
    a_cal_on_rise: assert property (p_cal_on_rise) else $error("active cal bit rose without start"); // RULE_16

    property p_cal_held;
        @(posedge pclk) disable iff (!presetn)
        $stable(st.act_cal[CSPC_CAL_BIT]) |-> !cal_start;
    endproperty
    a_cal_held: assert property (p_cal_held) else $error("calibration restarted with bit held"); // RULE_16
endmodule : cspc_top

// *** verification/cspc_host_bfm.sv ***
// cspc_host_bfm: apb master standing in for host software that programs the block.
// assumes a slave that answers on pready, sampled at rising edges of pclk.
`timescale 1ns/1ns
module cspc_host_bfm
    import cspc_pkg::*;
(
    input  wire logic                         pclk,    // apb clock
    input  wire logic [31:0]                  prdata,  // read data
    input  wire logic                         pready,  // ready
    input  wire logic                         pslverr, // error
    output logic                              psel,    // select
    output logic                              penable, // enable
    output logic                              pwrite,  // direction
    output logic      [cspc_pkg::CSPC_AW+1:0] paddr,   // byte address
    output logic      [31:0]                  pwdata,  // write data
    output logic      [3:0]                   pstrb    // byte strobes
);
    import cspc_pkg::*;
    // quiet bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'h0;
    end
    // one transfer; released lines show inverted data so a stale value never passes
    task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] wd,
                        input logic [3:0] strb, output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        pstrb <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        // no limit here: only the bench watchdog may end a wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~paddr;
        pwdata <= ~pwdata;
    endtask : xfer
endmodule : cspc_host_bfm

// *** verification/tb_top.sv ***
// tb_top: scenario bench for cspc_top driven through the host apb model.
// assumes a 100 MHz pclk and a shortened calibration window of 3 cycles.
`timescale 1ns/1ns
module tb_top;
    import cspc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic [3:0]  pstrb;
    logic        pd, neg, byp, src, ivco, cst, cbusy, err;
    logic [2:0]  code;
    int          fails, n_checks, n_start, n_busy;
    cspc_top #(.CAL_CYCLES(3)) u_dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pll_powerdown(pd), .pfd_negative(neg), .vco_div_code(code), .vco_div_bypass(byp),
        .src_internal_vco(src), .int_vco_enable(ivco), .cal_start(cst), .cal_busy(cbusy));
    cspc_host_bfm u_host(.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
    initial pclk = 1'b0;
    always #5 pclk = ~pclk;
    // count start pulses and busy cycles apart from the design's own counter;
    // sampled on the falling edge so the flip-flop outputs have settled
    always @(negedge pclk) begin
        if (cst === 1'b1) n_start++;
        if (cbusy === 1'b1) n_busy++;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [31:0] outs();
        return {24'h0, pd, neg, code, byp, src, ivco};
    endfunction : outs
    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        u_host.xfer(1'b1, idx, {24'h0, d}, 4'h1, v, err);
    endtask : wr
    task automatic rd(input logic [11:0] idx);
        u_host.xfer(1'b0, idx, 32'h0, 4'h0, v, err);
    endtask : rd
    // update strobe, then let the active copy settle
    task automatic upd();
        wr(CSPC_IDX_UPDATE, CSPC_UPD_VALUE);
        repeat (2) @(posedge pclk);
    endtask : upd
    task automatic t_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        chk(outs(), 32'h90);
        rd(CSPC_IDX_PWR_POL);
        chk(v, 32'h01);
        rd(CSPC_IDX_UPDATE);
        chk(v, 32'h00);
    endtask : t_reset
    // pll on with the external clock as source, negative polarity
    task automatic t_stage();
        wr(CSPC_IDX_PWR_POL, 8'h80);
        chk(outs(), 32'h90);
        rd(CSPC_IDX_PWR_POL);
        chk(v, 32'h80);
        wr(CSPC_IDX_UPDATE, 8'h02);
        repeat (2) @(posedge pclk);
        chk(outs(), 32'h90);
        upd();
        chk(outs(), 32'h50);
    endtask : t_stage
    task automatic t_path();
        for (int c = 0; c <= 4; c++) begin
            wr(CSPC_IDX_VDIV_SEL, 8'(c));
            upd();
            chk(outs(), {24'h0, 2'b01, 3'(c), 3'b000});
        end
        wr(CSPC_IDX_DIST_SEL, 8'h01);
        upd();
        chk(outs(), 32'h64);
        wr(CSPC_IDX_DIST_SEL, 8'h02);
        upd();
        chk(outs(), 32'h63);
        wr(CSPC_IDX_PWR_POL, 8'h81);
        upd();
        chk(outs(), 32'he2);
    endtask : t_path
    // power on, divider in path, vco source, then calibrate twice
    task automatic t_cal();
        wr(CSPC_IDX_PWR_POL, 8'h00);
        wr(CSPC_IDX_VCO_CAL, 8'h01);
        upd();
        repeat (8) @(posedge pclk);
        chk(n_start, 1);
        chk(n_busy, 3);
        upd();
        repeat (4) @(posedge pclk);
        chk(n_start, 1);
        wr(CSPC_IDX_VCO_CAL, 8'h00);
        upd();
        wr(CSPC_IDX_VCO_CAL, 8'h01);
        wr(CSPC_IDX_UPDATE, CSPC_UPD_VALUE);
        rd(CSPC_IDX_STATUS);
        chk(v, 32'h06);
        repeat (8) @(posedge pclk);
        chk(n_start, 2);
        chk(n_busy, 6);
        rd(CSPC_IDX_STATUS);
        chk(v, 32'h02);
    endtask : t_cal
    task automatic t_err();
        rd(12'h100);
        chk({v[30:0], err}, 32'h1);
        u_host.xfer(1'b1, CSPC_IDX_PWR_POL, 32'h01, 4'h0, v, err);
        rd(CSPC_IDX_PWR_POL);
        chk(v, 32'h00);
    endtask : t_err
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results
    initial begin
        presetn = 1'b0;
        t_reset();
        t_stage();
        t_path();
        t_cal();
        t_err();
        t_reset();
        results();
    end
    // cut a hang short well past the expected run time
    initial begin
        #100000;
        fails++;
        results();
    end
endmodule : tb_top
